/* File: logic/aec_ext_ctrl.sv */
`include "aec_cfg.svh"
// Operation
// - DMA overflow raises interrupt when bit 6
// - Buffer half-empty edge raises interrupt when bit 5, in extended mode only
// - Bit 4 gates every interrupt source
// - Bits 3..0 encode the interrupt line
// - Bit 6 enables extended-mode DMA requests
// - Bit 5 enables compatibility-mode DMA requests
// - Channel code read-only in bits 3..0
// - Gain code steps 1.5 dB to 22.5
// - Low nibble left, high nibble right gain
// - Eight formats from the two registers
// - Format register takes two successive bytes
// - FM index port then matching data port
// - FM index retained across data writes
// - FM file write-only, status readable
// - 243 FM registers in two banks
// - Voice frequency and key-on indices decoded
// - Rhythm index exists in bank 0 only
// - Register number then data on command port
// - Read command, number, then poll read buffer
module aec_ext_ctrl
  import aec_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [9:0] ioAddr,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire aec_pkg::aec_byte_t ioWdata,
  input wire logic [9:0] audioBase,
  output aec_pkg::aec_byte_t ioRdata,
  output logic ioRdHit,
  input wire logic extMode,
  input wire logic dmaOverflow,
  input wire logic bufHalfEmpty,
  input wire logic [3:0] dmaChanCode,
  input wire logic [7:0] fmStatusIn,
  output logic irqReq,
  output logic [3:0] irqLineSel,
  output logic dmaReq,
  input wire logic dmaWanted,
  output logic [3:0] gainLeft,
  output logic [3:0] gainRight,
  output logic [11:0] gainLeftCdb,
  output logic [11:0] gainRightCdb,
  output logic fmtStereo,
  output logic fmt16Bit,
  output logic fmtSigned,
  output logic fmtPlaySigned,
  output logic [7:0] fmLastIdx,
  output logic fmLastBank,
  output logic fmVoiceWr,
  output logic fmRhythmWr
);
  // ***************************************************************
  // Register state
  // ***************************************************************
  aec_cmd_state_t state_ff;
  aec_cmd_state_t nxt_state;
  aec_byte_t regNum_ff;
  aec_byte_t irqCtrl_ff;
  aec_byte_t dmaCtrl_ff;
  aec_byte_t gain_ff;
  aec_byte_t fmtInit_ff;
  aec_byte_t fmtCfg_ff;
  aec_byte_t fmtMode_ff;
  logic fmtSecond_ff;
  aec_byte_t rdBuf_ff;
  logic rdAvail_ff;
  logic halfPrev_ff;
  logic irq_ff;
  logic drq_ff;
  aec_byte_t rdata_ff;
  logic rdHit_ff;
  aec_byte_t fmStatus;

  // Gain code to centi-dB; 12 bits since the top code gives 2250
  function automatic logic [11:0] gain_cdb(input logic [3:0] code);
    gain_cdb = 12'(code) * `AEC_GAIN_STEP_CDB;
  endfunction

  // ***************************************************************
  // Port decode
  // ***************************************************************
  wire logic inAudio = (ioAddr[9:4] == audioBase[9:4]);
  wire logic cmdWr = ioWr && inAudio && (ioAddr[3:0] == `AEC_PORT_CMD);
  wire logic stsRd = ioRd && inAudio && (ioAddr[3:0] == `AEC_PORT_CMD);
  wire logic bufRd = ioRd && inAudio && (ioAddr[3:0] == `AEC_PORT_RDBUF);
  wire logic fmIdx0 = ioWr && (ioAddr == `AEC_PORT_FM_IDX0);
  wire logic fmIdx1 = ioWr && (ioAddr == `AEC_PORT_FM_IDX1);
  wire logic fmDat0 = ioWr && (ioAddr == `AEC_PORT_FM_DAT0);
  wire logic fmDat1 = ioWr && (ioAddr == `AEC_PORT_FM_DAT1);
  wire logic fmStsRd = ioRd && (ioAddr == `AEC_PORT_FM_IDX0);
  // Data port bank follows which data port is hit
  wire logic fmWrIdx = fmIdx0 || fmIdx1;
  wire logic fmWrDat = fmDat0 || fmDat1;
  wire logic fmBank = fmIdx1 || fmDat1;

  // Command sequencer: number then data, or C0h, number, then buffer
  wire logic isExtNum = (ioWdata[7:4] == 4'hA) || (ioWdata[7:4] == 4'hB);
  wire logic dataPhase = cmdWr && (state_ff == AEC_DATA);
  wire logic rdNumPhase = cmdWr && (state_ff == AEC_RDNUM);
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      AEC_IDLE: begin
        if (cmdWr && ioWdata == `AEC_CMD_READ_EN) begin
          nxt_state = AEC_RDNUM;
        end else if (cmdWr && isExtNum) begin
          nxt_state = AEC_DATA;
        end
      end
      AEC_DATA: begin
        if (cmdWr) begin
          nxt_state = AEC_IDLE;
        end
      end
      AEC_RDNUM: begin
        if (cmdWr) begin
          nxt_state = AEC_IDLE;
        end
      end
      default: nxt_state = AEC_IDLE;
    endcase
  end

  // Register read mux for the read-enable path
  wire aec_byte_t dmaView = {dmaCtrl_ff[7:4] & 4'hE, dmaChanCode};
  wire aec_byte_t fmtView = fmtSecond_ff ? fmtMode_ff : fmtCfg_ff;
  wire aec_byte_t regView =
    (ioWdata == `AEC_REG_IRQ_CTRL) ? (irqCtrl_ff & `AEC_IRQ_CTRL_MASK) :
    (ioWdata == `AEC_REG_DMA_CTRL) ? dmaView :
    (ioWdata == `AEC_REG_IN_GAIN) ? gain_ff :
    (ioWdata == `AEC_REG_FMT_INIT) ? fmtInit_ff :
    (ioWdata == `AEC_REG_FMT_CFG) ? fmtView : 8'h00;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= AEC_IDLE;
      regNum_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (cmdWr && state_ff == AEC_IDLE) begin
        regNum_ff <= ioWdata;
      end
    end
  end

  // ***************************************************************
  // Extended registers
  // ***************************************************************
  // Masks drop reserved and ignored bits at write time
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqCtrl_ff <= `AEC_IRQ_CTRL_RST;
      dmaCtrl_ff <= `AEC_DMA_CTRL_RST;
      gain_ff <= `AEC_GAIN_RST;
      fmtInit_ff <= `AEC_FMT_INIT_RST;
    end else if (dataPhase) begin
      if (regNum_ff == `AEC_REG_IRQ_CTRL) begin
        irqCtrl_ff <= ioWdata & `AEC_IRQ_CTRL_MASK;
      end
      if (regNum_ff == `AEC_REG_DMA_CTRL) begin
        dmaCtrl_ff <= ioWdata & `AEC_DMA_CTRL_MASK;
      end
      if (regNum_ff == `AEC_REG_IN_GAIN) begin
        gain_ff <= ioWdata;
      end
      if (regNum_ff == `AEC_REG_FMT_INIT) begin
        fmtInit_ff <= ioWdata;
      end
    end
  end

  // Format register alternates between the sign byte and the mode byte
  wire logic fmtWr = dataPhase && (regNum_ff == `AEC_REG_FMT_CFG);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fmtCfg_ff <= `AEC_FMT_CFG_RST;
      fmtMode_ff <= `AEC_FMT_MODE_RST;
      fmtSecond_ff <= 1'b0;
    end else if (fmtWr || (cmdWr && state_ff == AEC_IDLE && isExtNum
        && ioWdata == `AEC_REG_FMT_CFG && fmtSecond_ff)) begin
      if (fmtWr) begin
        if (fmtSecond_ff) begin
          fmtMode_ff <= ioWdata;
        end else begin
          fmtCfg_ff <= ioWdata;
        end
        fmtSecond_ff <= !fmtSecond_ff;
      end
    end
  end

  // Mode byte: bit 5 signed, bit 3 stereo, bit 2 16-bit
  assign fmtSigned = fmtMode_ff[5];
  assign fmtStereo = fmtMode_ff[3];
  assign fmt16Bit = fmtMode_ff[2];
  assign fmtPlaySigned = !fmtInit_ff[7];

  // ***************************************************************
  // Interrupt and DMA request generation
  // ***************************************************************
  // Half-empty interrupt fires on each transition, only in extended mode
  wire logic halfEdge = extMode && (bufHalfEmpty != halfPrev_ff);
  wire logic ovfSrc = dmaOverflow && irqCtrl_ff[`AEC_BIT_DMA_OVF_IE];
  wire logic halfSrc = halfEdge && irqCtrl_ff[`AEC_BIT_HALF_IE];
  wire logic irqSet = (ovfSrc || halfSrc) && irqCtrl_ff[`AEC_BIT_IRQ_EN];
  wire logic drqOk = extMode ? dmaCtrl_ff[`AEC_BIT_EXT_DRQ]
                             : dmaCtrl_ff[`AEC_BIT_COMP_DRQ];

  // Request held until status read or bit 4 cleared; a new event in that cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halfPrev_ff <= 1'b0;
      irq_ff <= 1'b0;
      drq_ff <= 1'b0;
    end else begin
      halfPrev_ff <= bufHalfEmpty;
      irq_ff <= irqSet || (irq_ff && !stsRd && irqCtrl_ff[`AEC_BIT_IRQ_EN]);
      drq_ff <= dmaWanted && drqOk;
    end
  end

  assign irqReq = irq_ff;
  assign irqLineSel = irqCtrl_ff[3:0];
  assign dmaReq = drq_ff;
  assign gainLeft = gain_ff[3:0];
  assign gainRight = gain_ff[7:4];
  assign gainLeftCdb = gain_cdb(gain_ff[3:0]);
  assign gainRightCdb = gain_cdb(gain_ff[7:4]);

  // ***************************************************************
  // Read buffer and host read data
  // ***************************************************************
  // Data-available flag: set by the register number after the read command, cleared by buffer read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdBuf_ff <= 8'h00;
      rdAvail_ff <= 1'b0;
    end else begin
      if (rdNumPhase) begin
        rdBuf_ff <= regView;
      end
      rdAvail_ff <= rdNumPhase || (rdAvail_ff && !bufRd);
    end
  end

  wire aec_byte_t stsByte = {1'b0, rdAvail_ff, 6'b00_0000};
  wire aec_byte_t rdMux = stsRd ? stsByte : bufRd ? rdBuf_ff : fmStsRd ? fmStatus : 8'h00;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
      rdHit_ff <= 1'b0;
    end else begin
      rdata_ff <= rdMux;
      rdHit_ff <= stsRd || bufRd || fmStsRd;
    end
  end
  assign ioRdata = rdata_ff;
  assign ioRdHit = rdHit_ff;

  aec_fm_port u_fm (
    .clk(clk),
    .sys_rst(sys_rst),
    .fmWrIdx(fmWrIdx),
    .fmWrDat(fmWrDat),
    .fmBank(fmBank),
    .fmWdata(ioWdata),
    .fmStatusIn(fmStatusIn),
    .fmStatus(fmStatus),
    .fmLastIdx(fmLastIdx),
    .fmLastBank(fmLastBank),
    .fmVoiceWr(fmVoiceWr),
    .fmRhythmWr(fmRhythmWr)
  );

  // ***************************************************************
  // Checks
  // ***************************************************************
  // Master enable off: no source may raise or hold a request
  a_irq_master_off: assert property (@(posedge clk) disable iff (sys_rst)
    !irqCtrl_ff[4] |=> !irqReq) else $error("irq while disabled");
  a_ovf_irq_set: assert property (@(posedge clk) disable iff (sys_rst)
    dmaOverflow && irqCtrl_ff[6] && irqCtrl_ff[4] |=> irqReq) else $error("ovf irq lost");
  a_half_irq_off: assert property (@(posedge clk) disable iff (sys_rst)
    !irqCtrl_ff[5] && !dmaOverflow && !irqReq |=> !irqReq) else $error("spurious irq");
  a_half_irq_set: assert property (@(posedge clk) disable iff (sys_rst)
    halfEdge && irqCtrl_ff[5] && irqCtrl_ff[4] |=> irqReq) else $error("half irq lost");
  // Outside extended mode buffer transitions stay silent
  a_half_compat: assert property (@(posedge clk) disable iff (sys_rst)
    !extMode && !dmaOverflow && !irqReq |=> !irqReq) else $error("compat half irq");
  // Requests follow the enable of the mode in force, one cycle late
  a_drq_ext_off: assert property (@(posedge clk) disable iff (sys_rst)
    extMode && !dmaCtrl_ff[6] |=> !dmaReq) else $error("ext drq while off");
  a_drq_ext_on: assert property (@(posedge clk) disable iff (sys_rst)
    extMode && dmaCtrl_ff[6] && dmaWanted |=> dmaReq) else $error("ext drq lost");
  a_drq_comp_off: assert property (@(posedge clk) disable iff (sys_rst)
    !extMode && !dmaCtrl_ff[5] |=> !dmaReq) else $error("comp drq while off");
  a_drq_comp_on: assert property (@(posedge clk) disable iff (sys_rst)
    !extMode && dmaCtrl_ff[5] && dmaWanted |=> dmaReq) else $error("comp drq lost");
  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !irqCtrl_ff[7] && dmaCtrl_ff[4:0] == 5'b0_0000) else $error("reserved bit set");
  // Channel code comes from the pins, never from a host write
  a_chan_code: assert property (@(posedge clk) disable iff (sys_rst)
    rdNumPhase && ioWdata == `AEC_REG_DMA_CTRL
    |=> rdBuf_ff[4:0] == {1'b0, $past(dmaChanCode)}) else $error("channel code wrong");
  // Register writes show on the outputs in the next cycle
  a_line_follows: assert property (@(posedge clk) disable iff (sys_rst)
    dataPhase && regNum_ff == `AEC_REG_IRQ_CTRL
    |=> irqLineSel == $past(ioWdata[3:0])) else $error("line code not taken");
  a_gain_nibbles: assert property (@(posedge clk) disable iff (sys_rst)
    dataPhase && regNum_ff == `AEC_REG_IN_GAIN |=> gainLeft == $past(ioWdata[3:0])
    && gainRight == $past(ioWdata[7:4])) else $error("gain nibbles swapped");
  a_gain_split: assert property (@(posedge clk) disable iff (sys_rst)
    gainRightCdb == 12'(gainRight) * 12'd150) else $error("gain map wrong");
  // Format bytes alternate; a lost toggle would swap sign and mode bytes
  a_fmt_toggle: assert property (@(posedge clk) disable iff (sys_rst)
    fmtWr |=> fmtSecond_ff != $past(fmtSecond_ff)) else $error("format byte order");
  a_fmt_first: assert property (@(posedge clk) disable iff (sys_rst)
    fmtWr && !fmtSecond_ff |=> fmtCfg_ff == $past(ioWdata)) else $error("sign byte lost");
  // Read path: flag set by the number, cleared by the buffer read
  a_rdavail_flag: assert property (@(posedge clk) disable iff (sys_rst)
    rdNumPhase |=> rdAvail_ff) else $error("avail missing");
  a_avail_clear: assert property (@(posedge clk) disable iff (sys_rst)
    bufRd && !rdNumPhase |=> !rdAvail_ff) else $error("avail not cleared");
  a_status_byte: assert property (@(posedge clk) disable iff (sys_rst)
    stsRd |=> ioRdHit && ioRdata[6] == $past(rdAvail_ff)) else $error("status flag wrong");
  a_fm_status: assert property (@(posedge clk) disable iff (sys_rst)
    fmStsRd |=> ioRdHit && ioRdata == $past(fmStatus)) else $error("fm status wrong");
  // A stray answer would be taken by the host as data
  a_read_refused: assert property (@(posedge clk) disable iff (sys_rst)
    !(stsRd || bufRd || fmStsRd) |=> !ioRdHit && ioRdata == 8'h00)
    else $error("stray read data");
  // Main scenarios: write, read-back, interrupt, mode byte, rhythm strobe
  c_ext_write: cover property (@(posedge clk) disable iff (sys_rst) dataPhase);
  c_reg_read: cover property (@(posedge clk) disable iff (sys_rst) rdNumPhase ##[1:20] bufRd);
  c_irq_raise: cover property (@(posedge clk) disable iff (sys_rst) irqSet);
  c_fmt_mode: cover property (@(posedge clk) disable iff (sys_rst) fmtWr && fmtSecond_ff);
  c_fm_rhythm: cover property (@(posedge clk) disable iff (sys_rst) fmRhythmWr);
endmodule

/* File: logic/aec_cfg.svh */
`ifndef AEC_CFG_SVH
`define AEC_CFG_SVH
// Extended register numbers
`define AEC_REG_IRQ_CTRL 8'hB1
`define AEC_REG_DMA_CTRL 8'hB2
`define AEC_REG_IN_GAIN 8'hB4
`define AEC_REG_FMT_INIT 8'hB6
`define AEC_REG_FMT_CFG 8'hB7
`define AEC_CMD_READ_EN 8'hC0
// Port offsets (low 4 bits of audio base, full FM address)
`define AEC_PORT_CMD 4'hC
`define AEC_PORT_RDBUF 4'hA
`define AEC_PORT_FM_IDX0 10'h388
`define AEC_PORT_FM_DAT0 10'h389
`define AEC_PORT_FM_IDX1 10'h38A
`define AEC_PORT_FM_DAT1 10'h38B
// Field positions
`define AEC_BIT_DMA_OVF_IE 6
`define AEC_BIT_HALF_IE 5
`define AEC_BIT_IRQ_EN 4
`define AEC_BIT_EXT_DRQ 6
`define AEC_BIT_COMP_DRQ 5
`define AEC_BIT_STS_RDAV 6
// Writable masks and reset values
`define AEC_IRQ_CTRL_MASK 8'h7F
`define AEC_DMA_CTRL_MASK 8'hE0
`define AEC_IRQ_CTRL_RST 8'h05
`define AEC_DMA_CTRL_RST 8'h00
`define AEC_GAIN_RST 8'h00
`define AEC_FMT_INIT_RST 8'h80
`define AEC_FMT_CFG_RST 8'h51
`define AEC_FMT_MODE_RST 8'hD0
// Line and channel encodings
`define AEC_SEL_OTHER 4'b0000
`define AEC_SEL_A 4'b0101
`define AEC_SEL_B 4'b1010
`define AEC_SEL_C 4'b1111
// FM file
`define AEC_FM_COUNT 243
`define AEC_FM_RHYTHM_IDX 8'hBD
`define AEC_FM_FREQ_LO_FIRST 8'hA0
`define AEC_FM_FREQ_LO_LAST 8'hA8
`define AEC_FM_KEY_ON_FIRST 8'hB0
`define AEC_FM_KEY_ON_LAST 8'hB8
// Gain step per code, centi-dB
`define AEC_GAIN_STEP_CDB 12'd150
`endif

/* File: logic/aec_pkg.sv */
package aec_pkg;
  typedef enum logic [1:0] {
    AEC_IDLE = 2'b00,
    AEC_DATA = 2'b01,
    AEC_RDNUM = 2'b10
  } aec_cmd_state_t;
  typedef logic [7:0] aec_byte_t;
endpackage

/* File: logic/aec_fm_port.sv */
`include "aec_cfg.svh"
// ***************************************************************
// FM index/data port with two write-only banks
// ***************************************************************
module aec_fm_port
  import aec_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fmWrIdx,
  input wire logic fmWrDat,
  input wire logic fmBank,
  input wire aec_pkg::aec_byte_t fmWdata,
  input wire logic [7:0] fmStatusIn,
  output aec_pkg::aec_byte_t fmStatus,
  output logic [7:0] fmLastIdx,
  output logic fmLastBank,
  output logic fmVoiceWr,
  output logic fmRhythmWr
);
  aec_byte_t idx0_ff;
  aec_byte_t idx1_ff;
  logic bank_ff;
  aec_byte_t bank0Mem [0:255];
  aec_byte_t bank1Mem [0:255];
  logic voice_ff;
  logic rhythm_ff;
  aec_byte_t status_ff;

  // Index held until rewritten, so repeated data writes reuse it
  wire aec_byte_t curIdx = fmBank ? idx1_ff : idx0_ff;
  // Frequency low A0-A8 and key-on/block B0-B8 decoded in both banks
  wire logic isFreqLo = (curIdx >= `AEC_FM_FREQ_LO_FIRST)
                        && (curIdx <= `AEC_FM_FREQ_LO_LAST);
  wire logic isKeyOn = (curIdx >= `AEC_FM_KEY_ON_FIRST)
                       && (curIdx <= `AEC_FM_KEY_ON_LAST);
  // Rhythm control is a bank 0 index only
  wire logic isRhythm = !fmBank && (curIdx == `AEC_FM_RHYTHM_IDX);

  // Index latches, bank picked by which index port was hit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx0_ff <= 8'h00;
      idx1_ff <= 8'h00;
      bank_ff <= 1'b0;
    end else if (fmWrIdx) begin
      if (fmBank) begin
        idx1_ff <= fmWdata;
      end else begin
        idx0_ff <= fmWdata;
      end
      bank_ff <= fmBank;
    end
  end

  // Register storage; the file is never read back by the host
  always_ff @(posedge clk) begin
    if (fmWrDat && !fmBank) begin
      bank0Mem[curIdx] <= fmWdata;
    end
    if (fmWrDat && fmBank && !(curIdx == `AEC_FM_RHYTHM_IDX)) begin
      bank1Mem[curIdx] <= fmWdata;
    end
  end

  // Write strobes towards the voice engine, plus registered status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      voice_ff <= 1'b0;
      rhythm_ff <= 1'b0;
      status_ff <= 8'h00;
    end else begin
      voice_ff <= fmWrDat && (isFreqLo || isKeyOn);
      rhythm_ff <= fmWrDat && isRhythm;
      status_ff <= fmStatusIn;
    end
  end

  assign fmStatus = status_ff;
  assign fmLastIdx = bank_ff ? idx1_ff : idx0_ff;
  assign fmLastBank = bank_ff;
  assign fmVoiceWr = voice_ff;
  assign fmRhythmWr = rhythm_ff;

  a_bank1_rhythm: assert property (@(posedge clk) disable iff (sys_rst)
    fmWrDat && fmBank |=> !fmRhythmWr) else $error("rhythm strobe from bank 1");
  a_index_kept: assert property (@(posedge clk) disable iff (sys_rst)
    !fmWrIdx |=> idx0_ff == $past(idx0_ff)) else $error("index changed");
endmodule

/* File: sim/aec_host.sv */
`include "aec_cfg.svh"
// ****************************************
// Host model: I/O port cycles
// ****************************************
module aec_host
  import aec_pkg::*;
#(
  parameter logic [9:0] BASE = 10'h220
)
(
  input wire logic clk,
  output logic [9:0] ioAddr,
  output logic ioWr,
  output logic ioRd,
  output aec_pkg::aec_byte_t ioWdata,
  input wire aec_pkg::aec_byte_t ioRdata,
  input wire logic ioRdHit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    ioAddr = 10'h000;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWdata = 8'h00;
  end
  // One-cycle strobe; released lines flip so stale values never pass
  task automatic wr(input logic [9:0] a, input aec_byte_t d);
    @(negedge clk);
    ioAddr = a;
    ioWdata = d;
    ioWr = 1'b1;
    @(negedge clk);
    ioWr = 1'b0;
    ioAddr = ~a;
    ioWdata = ~d;
  endtask
  // Answer awaited three cycles at most
  task automatic rd(input logic [9:0] a, output aec_byte_t d, output logic hit);
    @(negedge clk);
    ioAddr = a;
    ioRd = 1'b1;
    @(negedge clk);
    ioRd = 1'b0;
    ioAddr = ~a;
    hit = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 3 && hit !== 1'b1; i++) begin
      if (ioRdHit === 1'b1) begin
        hit = 1'b1;
        d = ioRdata;
      end else begin
        @(negedge clk);
      end
    end
  endtask
  // Extended register write: number, then data, same port
  task automatic xwr(input aec_byte_t r, input aec_byte_t d);
    wr(BASE + 10'h00C, r);
    wr(BASE + 10'h00C, d);
  endtask
  // Extended read; polling is bounded so a dead flag cannot hang us
  task automatic xrd(input aec_byte_t r, output aec_byte_t d);
    logic h;
    wr(BASE + 10'h00C, `AEC_CMD_READ_EN);
    wr(BASE + 10'h00C, r);
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rd(BASE + 10'h00C, d, h);
      if (d[`AEC_BIT_STS_RDAV] === 1'b1) break;
    end
    rd(BASE + 10'h00A, d, h);
  endtask
endmodule

/* File: sim/audio_ext_control_and_fm_port_tb.sv */
// ****************************************
// Bench for extended control and FM port
// ****************************************
module audio_ext_control_and_fm_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aec_pkg::*;
  localparam logic [9:0] BASE = 10'h220;
  localparam logic [7:0] FMT2 [8] = '{8'hD0, 8'hF0, 8'hD4, 8'hF4, 8'h98, 8'hB8, 8'h9C, 8'hBC};
  localparam logic [7:0] IRQV [4] = '{8'h55, 8'h15, 8'h35, 8'h65};
  localparam logic [8:0] FMC [8] = '{9'h0A0, 9'h1A8, 9'h0B8, 9'h1B0, 9'h0BD, 9'h1BD, 9'h0A9,
                                     9'h120};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] ioAddr;
  aec_byte_t ioWdata, ioRdata;
  logic ioWr, ioRd, ioRdHit, extMode, dmaOverflow, bufHalfEmpty, dmaWanted, irqReq, dmaReq;
  logic fmLastBank, fmVoiceWr, fmRhythmWr, fmtStereo, fmt16Bit, fmtSigned, fmtPlaySigned;
  logic [3:0] dmaChanCode, irqLineSel, gainLeft, gainRight;
  logic [7:0] fmStatusIn, fmLastIdx;
  logic [11:0] gainLeftCdb, gainRightCdb;
  int errorCnt = 0;
  int nChecks = 0;
  int cyc = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  aec_host #(.BASE(BASE)) H (
    .clk(clk), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWdata(ioWdata),
    .ioRdata(ioRdata), .ioRdHit(ioRdHit)
  );
  aec_ext_ctrl DUT (
    .clk(clk), .sys_rst(sys_rst), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioWdata(ioWdata), .audioBase(BASE), .ioRdata(ioRdata), .ioRdHit(ioRdHit),
    .extMode(extMode), .dmaOverflow(dmaOverflow), .bufHalfEmpty(bufHalfEmpty),
    .dmaChanCode(dmaChanCode), .fmStatusIn(fmStatusIn), .irqReq(irqReq),
    .irqLineSel(irqLineSel), .dmaReq(dmaReq), .dmaWanted(dmaWanted),
    .gainLeft(gainLeft), .gainRight(gainRight), .gainLeftCdb(gainLeftCdb),
    .gainRightCdb(gainRightCdb), .fmtStereo(fmtStereo), .fmt16Bit(fmt16Bit),
    .fmtSigned(fmtSigned), .fmtPlaySigned(fmtPlaySigned), .fmLastIdx(fmLastIdx),
    .fmLastBank(fmLastBank), .fmVoiceWr(fmVoiceWr), .fmRhythmWr(fmRhythmWr)
  );
  // Compare and count
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    nChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic finalReport();
    if (errorCnt == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      finalReport();
    end
  end
  // Expected write kind: bit 0 voice, bit 1 rhythm
  function automatic logic [1:0] fmKind(input logic [8:0] c);
    fmKind[0] = c[7:0] inside {[8'hA0:8'hA8], [8'hB0:8'hB8]};
    fmKind[1] = (c == 9'h0BD);
  endfunction
  // Case 2 toggles half-empty only, case 3 fires both sources
  function automatic logic irqExp(input logic [7:0] r, input int i);
    irqExp = r[4] && ((i != 2 && r[6]) || (i >= 2 && r[5]));
  endfunction
  // Pulses may land in either of two cycles after the write
  task automatic watchFm(output logic [1:0] s);
    s = {fmRhythmWr, fmVoiceWr};
    @(negedge clk);
    s = s | {fmRhythmWr, fmVoiceWr};
  endtask
  // Main sequence
  initial begin
    logic [7:0] w, v;
    logic [1:0] s;
    logic hit;
    extMode = 1'b1;
    dmaOverflow = 1'b0;
    bufHalfEmpty = 1'b0;
    dmaWanted = 1'b1;
    dmaChanCode = 4'b0101;
    fmStatusIn = 8'h00;
    void'($urandom(77491));
    repeat (6) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk("irqLineSel", 12'h005, 12'(irqLineSel));
    H.xrd(8'hB2, v);
    chk("dma_request_control", 12'h005, 12'(v));
    H.xrd(8'hB7, v);
    chk("sample_format_config", 12'h051, 12'(v));
    // Line codes; reserved bit 7 must read back clear
    for (int i = 0; i < 4; i++) begin
      w = {4'($urandom), {2{2'(i)}}};
      H.xwr(8'hB1, w);
      chk("irqLineSel", 12'(w[3:0]), 12'(irqLineSel));
      H.xrd(8'hB1, v);
      chk("irq_control", 12'(w & 8'h7F), 12'(v));
    end
    // Request enable per mode, channel code read only
    for (int i = 0; i < 8; i++) begin
      w = {1'b0, 2'(i), 5'($urandom)};
      extMode = i[2];
      dmaWanted = (i != 3);
      dmaChanCode = {2{2'($urandom)}};
      H.xwr(8'hB2, w);
      H.xrd(8'hB2, v);
      chk("dma_request_control", 12'({w[7:5], 1'b0, dmaChanCode}), 12'(v));
      chk("dmaReq", 12'(dmaWanted && (extMode ? w[6] : w[5])), 12'(dmaReq));
    end
    // Interrupt sources with their enables; overflow also without its enable
    extMode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      H.xwr(8'hB1, IRQV[i]);
      H.rd(BASE + 10'h00C, v, hit);
      dmaOverflow = (i != 2);
      bufHalfEmpty = bufHalfEmpty ^ (i >= 2);
      @(negedge clk);
      dmaOverflow = 1'b0;
      repeat (2) @(negedge clk);
      chk("irqReq", 12'(irqExp(IRQV[i], i)), 12'(irqReq));
      H.rd(BASE + 10'h00C, v, hit);
      chk("irqReq", 12'h000, 12'(irqReq));
    end
    // Half-empty changes outside extended mode stay silent
    extMode = 1'b0;
    H.xwr(8'hB1, 8'h35);
    bufHalfEmpty = ~bufHalfEmpty;
    repeat (2) @(negedge clk);
    chk("irqReq", 12'h000, 12'(irqReq));
    // Gain codes, corners first
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 8'hF0 : (i == 1) ? 8'h0F : 8'($urandom);
      H.xwr(8'hB4, w);
      chk("gainLeft", 12'(w[3:0]), 12'(gainLeft));
      chk("gainRight", 12'(w[7:4]), 12'(gainRight));
      chk("gainLeftCdb", 12'(w[3:0]) * 12'd150, 12'(gainLeftCdb));
      chk("gainRightCdb", 12'(w[7:4]) * 12'd150, 12'(gainRightCdb));
    end
    // All eight formats: index bit 0 signed, bit 1 wide, bit 2 stereo
    for (int i = 0; i < 8; i++) begin
      H.xwr(8'hB6, i[0] ? 8'h00 : 8'h80);
      H.xwr(8'hB7, i[0] ? 8'h71 : 8'h51);
      H.xwr(8'hB7, FMT2[i]);
      chk("fmtSigned", 12'(i[0]), 12'(fmtSigned));
      chk("fmt16Bit", 12'(i[1]), 12'(fmt16Bit));
      chk("fmtStereo", 12'(i[2]), 12'(fmtStereo));
      chk("fmtPlaySigned", 12'(i[0]), 12'(fmtPlaySigned));
    end
    H.xrd(8'hB7, v);
    chk("sample_format_config", 12'h071, 12'(v));
    // FM index then two data writes on the held index
    for (int i = 0; i < 8; i++) begin
      H.wr(10'h388 + 10'({FMC[i][8], 1'b0}), FMC[i][7:0]);
      for (int k = 0; k < 2; k++) begin
        H.wr(10'h389 + 10'({FMC[i][8], 1'b0}), 8'($urandom));
        watchFm(s);
        chk("fm write kind", 12'(fmKind(FMC[i])), 12'(s));
        chk("fmLastIdx", 12'(FMC[i][7:0]), 12'(fmLastIdx));
        chk("fmLastBank", 12'(FMC[i][8]), 12'(fmLastBank));
      end
    end
    // Status is the only readable FM place
    fmStatusIn = 8'($urandom);
    H.rd(10'h388, v, hit);
    chk("fm_status", {4'h1, fmStatusIn}, {3'h0, hit, v});
    H.rd(10'h389, v, hit);
    chk("fm data read hit", 12'h000, 12'(hit));
    H.rd(10'h300, v, hit);
    chk("unmapped read hit", 12'h000, 12'(hit));
    finalReport();
  end
endmodule
